/* File: core/nbp_cycle.sv */
// Module: one strobed cycle on the multiplexed NAND bus
`timescale 1ns/10ps
module nbp_cycle (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Request side
    input wire logic start,
    input wire nbp_pkg::nbp_cycle_t cyc,
    output logic done,
    output logic [7:0] rd_data,
    // Pins
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in_sync
);
    logic [1:0] cnt;
    logic phase;
    logic busy;

    // ==========================================================
    // Low phase then high phase, PHASE_CYC cycles each
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
            phase <= 1'b0;
            cnt <= 2'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                busy <= 1'b1;
                phase <= 1'b0;
                cnt <= 2'h0;
            end else if (busy) begin
                if (cnt == nbp_pkg::PHASE_CYC - 2'h1) begin
                    cnt <= 2'h0;
                    phase <= ~phase;
                    if (phase) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            io_out <= 8'h00;
            io_oe <= 1'b0;
        end else if (!busy && start) begin
            cmd_latch <= cyc.is_cmd;
            addr_latch <= cyc.is_addr;
            io_out <= cyc.data;
            io_oe <= !cyc.is_read;
        end else if (done) begin
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            io_oe <= 1'b0;
        end
    end

    logic is_read_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            is_read_q <= 1'b0;
        end else if (!busy && start) begin
            is_read_q <= cyc.is_read;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            rd_data <= 8'h00;
        end else begin
            write_strobe_n <= !(busy && !phase && !is_read_q);
            read_strobe_n <= !(busy && !phase && is_read_q);
            // Input passes two sync flops: sample at end of high phase
            if (busy && phase && is_read_q
                && cnt == nbp_pkg::PHASE_CYC - 2'h1) begin
                rd_data <= io_in_sync;
            end
        end
    end
endmodule : nbp_cycle

/* File: core/nbp_host.sv */
// Module: host controller for NAND power-up, reset and lock status read
//
// Summary of operation
// - Status query: 7Ah, three addresses, one data
// - Block number split over three address bytes
// - Reset FFh first, before any command
// - Poll busy line or status 70h
// - Hold write-protect low during power changes
// - Write-protect settled before setup strobe
`timescale 1ns/10ps
module nbp_host #(
    parameter int RB_VALID_CYCLES = nbp_pkg::RB_VALID_CYC,
    parameter int RST_BUSY_CYCLES = nbp_pkg::RST_BUSY_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // User command port
    input wire logic req_valid,
    input wire nbp_pkg::nbp_op_t req_op,
    input wire logic [11:0] req_block,
    input wire logic power_good,
    input wire logic wp_allow,
    input wire logic wp_abort,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output nbp_pkg::nbp_lock_info_t rsp_lock,
    output logic rsp_timeout,
    output logic init_done,
    // NAND pins
    output logic chip_enable_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic write_protect_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n
);
    // ==========================================================
    // State encoding
    typedef enum logic [3:0] {
        ST_OFF = 4'b0000,
        ST_RB_WAIT = 4'b0001,
        ST_RST_CMD = 4'b0010,
        ST_RST_WAIT = 4'b0011,
        ST_RST_POLL = 4'b0100,
        ST_IDLE = 4'b0101,
        ST_CMD = 4'b0110,
        ST_ADDR = 4'b0111,
        ST_GAP = 4'b1000,
        ST_DATA = 4'b1001
    } nbp_host_state_t;

    nbp_host_state_t state;
    logic [15:0] wait_cnt;
    logic [1:0] addr_idx;
    nbp_pkg::nbp_op_t op_q;
    logic [11:0] blk_q;
    logic cyc_start;
    logic cyc_done;
    nbp_pkg::nbp_cycle_t cyc_word;
    logic [7:0] cyc_rd;
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic rb_meta;
    logic rb_sync;
    logic [2:0] wp_cnt;
    logic accept;
    logic poll_late;
    logic poll_end;

    // ==========================================================
    // Helpers
    function automatic nbp_pkg::nbp_cycle_t bus_word(
        input logic is_cmd,
        input logic is_addr,
        input logic [7:0] value
    );
        nbp_pkg::nbp_cycle_t w;
        w.is_cmd = is_cmd;
        w.is_addr = is_addr;
        w.is_read = !is_cmd && !is_addr;
        w.data = value;
        return w;
    endfunction : bus_word

    function automatic logic [7:0] op_cmd(
        input nbp_pkg::nbp_op_t op
    );
        logic [7:0] c;
        case (op)
            nbp_pkg::NBP_OP_RESET: c = nbp_pkg::CMD_RESET;
            nbp_pkg::NBP_OP_PROT_READ: c = nbp_pkg::CMD_PROT_READ;
            default: c = nbp_pkg::CMD_STATUS;
        endcase
        return c;
    endfunction : op_cmd

    function automatic logic [7:0] addr_byte(
        input logic [11:0] blk,
        input logic [1:0] idx
    );
        logic [7:0] b;
        case (idx)
            2'h0: b = {blk[1:0], 6'h00};
            2'h1: b = blk[9:2];
            default: b = {6'h00, blk[11:10]};
        endcase
        return b;
    endfunction : addr_byte

    function automatic nbp_pkg::nbp_lock_info_t lock_decode(
        input logic [7:0] s
    );
        nbp_pkg::nbp_lock_info_t l;
        l.permanent_lockdown = s[nbp_pkg::LOCK_PERM_DOWN_BIT];
        l.permanent_block_guard = !s[nbp_pkg::LOCK_PERM_OPEN_BIT];
        l.volatile_block_guard = !s[nbp_pkg::LOCK_VOL_OPEN_BIT];
        l.volatile_lockdown = s[nbp_pkg::LOCK_VOL_DOWN_BIT];
        l.pair_error = s[nbp_pkg::LOCK_VOL_DOWN_BIT]
            == s[nbp_pkg::LOCK_VOL_NOT_DOWN_BIT];
        l.reserved_error = |s[7:nbp_pkg::LOCK_RSVD_LSB];
        return l;
    endfunction : lock_decode

    // ==========================================================
    // Pin synchronisers
    // Busy line sampled
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            io_meta <= 8'h00;
            io_sync <= 8'h00;
            rb_meta <= 1'b1;
            rb_sync <= 1'b1;
        end else begin
            io_meta <= io_in;
            io_sync <= io_meta;
            rb_meta <= ready_busy_n;
            rb_sync <= rb_meta;
        end
    end

    // ==========================================================
    // Handshake
    // Reset busy bounded
    assign poll_late = wait_cnt == 16'(RST_BUSY_CYCLES - 1);
    assign poll_end = (state == ST_RST_POLL) && (rb_sync || poll_late);
    assign req_ready = (state == ST_IDLE)
        && (rb_sync || req_op == nbp_pkg::NBP_OP_STATUS);
    assign accept = req_valid && req_ready;

    // ==========================================================
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_OFF;
            wait_cnt <= 16'h0000;
            addr_idx <= 2'h0;
            cyc_start <= 1'b0;
            cyc_word <= '0;
            op_q <= nbp_pkg::NBP_OP_STATUS;
            blk_q <= 12'h000;
        end else if (!power_good) begin
            state <= ST_OFF;
            wait_cnt <= 16'h0000;
            cyc_start <= 1'b0;
        end else begin
            cyc_start <= 1'b0;
            case (state)
                ST_OFF: begin
                    wait_cnt <= 16'h0000;
                    state <= ST_RB_WAIT;
                end
                ST_RB_WAIT: begin
                    if (wait_cnt == 16'(RB_VALID_CYCLES - 1)) begin
                        cyc_start <= 1'b1;
                        cyc_word <= bus_word(1'b1, 1'b0,
                            nbp_pkg::CMD_RESET);
                        state <= ST_RST_CMD;
                    end else begin
                        wait_cnt <= wait_cnt + 16'h0001;
                    end
                end
                ST_RST_CMD: begin
                    if (cyc_done) begin
                        wait_cnt <= 16'h0000;
                        state <= ST_RST_WAIT;
                    end
                end
                // Busy edge lags the strobe; polling early reads ready
                ST_RST_WAIT: begin
                    if (wait_cnt == 16'(nbp_pkg::RB_SETTLE_CYC - 1)) begin
                        wait_cnt <= 16'h0000;
                        state <= ST_RST_POLL;
                    end else begin
                        wait_cnt <= wait_cnt + 16'h0001;
                    end
                end
                ST_RST_POLL: begin
                    if (poll_end) begin
                        state <= ST_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 16'h0001;
                    end
                end
                ST_IDLE: begin
                    if (accept) begin
                        op_q <= req_op;
                        blk_q <= req_block;
                        cyc_start <= 1'b1;
                        cyc_word <= bus_word(1'b1, 1'b0, op_cmd(req_op));
                        if (req_op == nbp_pkg::NBP_OP_RESET) begin
                            state <= ST_RST_CMD;
                        end else begin
                            state <= ST_CMD;
                        end
                    end
                end
                ST_CMD: begin
                    if (cyc_done) begin
                        wait_cnt <= 16'h0000;
                        if (op_q == nbp_pkg::NBP_OP_PROT_READ) begin
                            cyc_start <= 1'b1;
                            cyc_word <= bus_word(1'b0, 1'b1,
                                addr_byte(blk_q, 2'h0));
                            addr_idx <= 2'h1;
                            state <= ST_ADDR;
                        end else begin
                            state <= ST_GAP;
                        end
                    end
                end
                ST_ADDR: begin
                    if (cyc_done) begin
                        if (addr_idx == 2'(nbp_pkg::ADDR_CYCLES)) begin
                            wait_cnt <= 16'h0000;
                            state <= ST_GAP;
                        end else begin
                            cyc_start <= 1'b1;
                            cyc_word <= bus_word(1'b0, 1'b1,
                                addr_byte(blk_q, addr_idx));
                            addr_idx <= addr_idx + 2'h1;
                        end
                    end
                end
                // Write-to-read turnaround
                ST_GAP: begin
                    if (wait_cnt == 16'(nbp_pkg::WHR_CYC - 1)) begin
                        cyc_start <= 1'b1;
                        cyc_word <= bus_word(1'b0, 1'b0, 8'h00);
                        state <= ST_DATA;
                    end else begin
                        wait_cnt <= wait_cnt + 16'h0001;
                    end
                end
                ST_DATA: begin
                    if (cyc_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // ==========================================================
    // Responses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_lock <= '0;
            rsp_timeout <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == ST_DATA && cyc_done) begin
                rsp_valid <= 1'b1;
                rsp_data <= cyc_rd;
                if (op_q == nbp_pkg::NBP_OP_PROT_READ) begin
                    rsp_lock <= lock_decode(cyc_rd);
                end
            end else if (poll_end) begin
                // Power-up reset has no requester to answer
                rsp_valid <= init_done;
                // Limitation: a late reset still counts as initialised
                rsp_timeout <= !rb_sync;
            end else if (accept) begin
                rsp_timeout <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !power_good) begin
            init_done <= 1'b0;
        end else if (poll_end) begin
            init_done <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chip_enable_n <= 1'b1;
        end else begin
            chip_enable_n <= state inside {ST_OFF, ST_RB_WAIT, ST_IDLE};
        end
    end

    // ==========================================================
    // Write protect
    // Abort pulse held long enough
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wp_cnt <= 3'h0;
        end else if (wp_abort) begin
            wp_cnt <= 3'(nbp_pkg::WP_ABORT_CYC);
        end else if (wp_cnt != 3'h0) begin
            wp_cnt <= wp_cnt - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_protect_n <= 1'b0;
        end else begin
            write_protect_n <= power_good && wp_allow && !wp_abort
                && wp_cnt == 3'h0;
        end
    end

    // ==========================================================
    // Bus cycle engine
    // Bus released on reads
    nbp_cycle nbp_cycle_inst (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(cyc_start),
        .cyc(cyc_word),
        .done(cyc_done),
        .rd_data(cyc_rd),
        .cmd_latch(cmd_latch),
        .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n),
        .io_out(io_out),
        .io_oe(io_oe),
        .io_in_sync(io_sync)
    );
endmodule : nbp_host

/* File: core/nbp_pkg.sv */
// Package: constants and types for the NAND protection-status host controller
package nbp_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int RB_VALID_US = 100;
    localparam int RB_VALID_CYC = RB_VALID_US * (CLK_HZ / 1_000_000);
    localparam int RST_BUSY_MS = 2;
    localparam int RST_BUSY_CYC = RST_BUSY_MS * (CLK_HZ / 1_000);
    localparam int WP_ABORT_NS = 100;
    localparam int WP_ABORT_CYC = (WP_ABORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROT_SETUP_NS = 100;
    localparam int PROT_SETUP_CYC = (PROT_SETUP_NS + CLK_NS - 1) / CLK_NS;
    // Strobe phase length in cycles (covers setup/hold and access times)
    localparam logic [1:0] PHASE_CYC = 2'h2;
    localparam int WHR_NS = 60;
    localparam int WHR_CYC = (WHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int WB_NS = 100;
    localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
    // Strobe-to-busy delay plus two synchroniser stages
    localparam int RB_SETTLE_CYC = WB_CYC + 2;

    // ==========================================================
    // Commands
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_PROT_READ = 8'h7a;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam int ADDR_CYCLES = 3;

    // ==========================================================
    // Lock status and status byte fields
    localparam int LOCK_RSVD_LSB = 5;
    localparam int LOCK_PERM_DOWN_BIT = 4;
    localparam int LOCK_PERM_OPEN_BIT = 3;
    localparam int LOCK_VOL_OPEN_BIT = 2;
    localparam int LOCK_VOL_NOT_DOWN_BIT = 1;
    localparam int LOCK_VOL_DOWN_BIT = 0;
    localparam logic [7:0] LOCK_DEFAULT = 8'h0e;
    localparam int STAT_READY = 6;
    localparam int STAT_WP_N = 7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        NBP_OP_STATUS = 2'b00,
        NBP_OP_PROT_READ = 2'b01,
        NBP_OP_RESET = 2'b10
    } nbp_op_t;

    typedef struct packed {
        logic permanent_lockdown;
        logic permanent_block_guard;
        logic volatile_block_guard;
        logic volatile_lockdown;
        logic pair_error;
        logic reserved_error;
    } nbp_lock_info_t;

    // One bus cycle for the sequencer
    typedef struct packed {
        logic is_cmd;
        logic is_addr;
        logic is_read;
        logic [7:0] data;
    } nbp_cycle_t;
endpackage : nbp_pkg

/* File: verification/nbp_dev_model.sv */
// Partner: behavioural flash die answering status queries
`timescale 1ns/10ps
module nbp_dev_model #(
    parameter logic [11:0] LOCK_BLK = 12'ha5c
) (
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_out,
    output logic [7:0] io_in,
    output logic ready_busy_n
);
    // ====
    // Command decode
    logic [7:0] cmd = 8'h00;
    logic [1:0] na = 2'h0;
    logic [11:0] blk = 12'h000;
    logic [7:0] lock;
    initial ready_busy_n = 1'b1;
    always @(posedge write_strobe_n) begin
        if (cmd_latch) begin
            cmd = io_out;
            na = 2'h0;
            if (io_out == 8'hff) fork
                begin ready_busy_n = 1'b0; #1500 ready_busy_n = 1'b1; end
            join_none
        end else if (addr_latch) begin
            case (na)
                2'h0: blk[1:0] = io_out[7:6];
                2'h1: blk[9:2] = io_out;
                default: blk[11:10] = io_out[1:0];
            endcase
            na = na + 2'h1;
        end
    end
    assign lock = (blk == LOCK_BLK) ? 8'h11 : 8'h0e;
    assign io_in = read_strobe_n ? ~io_out : (cmd == 8'h70) ?
        {1'b1, ready_busy_n, 6'h00} : (na == 2'h3) ? lock : ~io_out;
endmodule : nbp_dev_model

/* File: verification/nbp_host_sva.sv */
// Checker: pin-level assertions for the host controller
`timescale 1ns/10ps
module nbp_host_sva (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic power_good,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic io_oe,
    input wire logic write_protect_n,
    input wire logic ready_busy_n,
    input wire logic [7:0] io_out
);
    // ====
    // Properties
    logic seen;
    wire wr_cmd = cmd_latch && !write_strobe_n;
    always_ff @(posedge sys_clk) seen <= srst ? 1'b0 : seen | wr_cmd;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence prot_cmd;
        wr_cmd && io_out == 8'h7a ##1 write_strobe_n;
    endsequence
    wp_low_a: assert property (!power_good |=> !write_protect_n)
        else $error("write protect high without power");
    first_reset_a: assert property (wr_cmd && !seen |-> io_out == 8'hff)
        else $error("first command is not reset");
    busy_poll_a: assert property (wr_cmd && !ready_busy_n |-> io_out == 8'h70)
        else $error("command other than status while busy");
    latch_excl_a: assert property (!(cmd_latch && addr_latch))
        else $error("command and address latch together");
    prot_addr_a: assert property (prot_cmd |=> (!wr_cmd) [*8])
        else $error("command inside status query addresses");
    strobe_excl_a: assert property (!(!write_strobe_n && !read_strobe_n))
        else $error("write and read strobe together");
    read_release_a: assert property (!read_strobe_n |-> !io_oe)
        else $error("bus driven during read");
    setup_wp_a: assert property (wr_cmd && io_out inside {8'h80, 8'h60}
        |-> write_protect_n && $past(write_protect_n, 2))
        else $error("write protect not settled at setup");
endmodule : nbp_host_sva
bind nbp_host nbp_host_sva nbp_host_sva_inst (.sys_clk(sys_clk),
    .srst(srst), .power_good(power_good), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .io_oe(io_oe),
    .write_protect_n(write_protect_n), .ready_busy_n(ready_busy_n),
    .io_out(io_out));

/* File: verification/nbp_host_tb.sv */
// Testbench: power-up, lock status and status poll
`timescale 1ns/10ps
module nbp_host_tb;
    // ====
    // Signals
    logic sys_clk = 0, srst = 1, req_valid = 0, power_good = 0;
    logic wp_allow = 1, wp_abort = 0, req_ready, rsp_valid, rsp_timeout;
    logic init_done, chip_enable_n, cmd_latch, addr_latch, io_oe;
    logic write_strobe_n, read_strobe_n, write_protect_n, ready_busy_n;
    logic [7:0] rsp_data, io_out, io_in, d;
    logic [11:0] req_block = 0;
    nbp_pkg::nbp_op_t req_op = nbp_pkg::NBP_OP_STATUS;
    nbp_pkg::nbp_lock_info_t rsp_lock;
    int fails = 0, check_count = 0;
    always #25 sys_clk = ~sys_clk;
    nbp_host #(.RB_VALID_CYCLES(40), .RST_BUSY_CYCLES(200)) nbp_host_inst(.*);
    nbp_dev_model nbp_dev_model_inst(.*);
    task automatic chk(input string s, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic req(input nbp_pkg::nbp_op_t op, input logic [11:0] b);
        int n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_block <= b;
        do @(posedge sys_clk); while (req_ready !== 1 && ++n < 500);
        req_valid <= 0;
        while (rsp_valid !== 1 && n++ < 2000) @(posedge sys_clk);
        chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
        d = rsp_data;
    endtask : req
    task automatic t_power;
        repeat (10) @(posedge sys_clk);
        chk("wp_low", 8'h00, {7'h0, write_protect_n});
        power_good <= 1;
        for (int n = 0; n < 3000 && init_done !== 1; n++) @(posedge sys_clk);
        chk("init_done", 8'h01, {7'h0, init_done});
    endtask : t_power
    task automatic t_prot;
        req(nbp_pkg::NBP_OP_PROT_READ, 12'h000);
        chk("lock_dflt", nbp_pkg::LOCK_DEFAULT, d);
        chk("info_dflt", 8'h00, {2'b00, rsp_lock});
        req(nbp_pkg::NBP_OP_PROT_READ, 12'ha5c);
        chk("lock_blk", 8'h11, d);
        chk("info_blk", 8'h3c, {2'b00, rsp_lock});
    endtask : t_prot
    task automatic t_reset;
        req(nbp_pkg::NBP_OP_RESET, 12'h000);
        chk("rst_tmo", 8'h00, {7'h0, rsp_timeout});
        @(posedge sys_clk);
        chk("ce_idle", 8'h01, {7'h0, chip_enable_n});
    endtask : t_reset
    task automatic t_status;
        req(nbp_pkg::NBP_OP_STATUS, 12'h000);
        chk("status", 8'hc0, d);
    endtask : t_status
    task automatic report_and_stop;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 0;
        t_power();
        t_prot();
        t_reset();
        t_status();
        report_and_stop();
    end
    initial begin
        #1000000 fails++;
        report_and_stop();
    end
endmodule : nbp_host_tb
